// ---- test_port_pkg.sv ----
// Constants and types for the test port and output-disable block
// Functional notes
// [R1] TMS and TDI are taken on each rising test clock edge into the TAP controller, instruction register or selected data register.
// [R2] The selected register shifts out on TDO, and TDO changes only on falling test clock edges.
// [R3] TDO is released (high impedance) except while a data or instruction scan is shifting.
// [R4] With test reset high the scan system controls the device.
// [R5] With test reset low the device runs functionally and ignores the test clock, TMS and TDI.
// [R6] With test reset high each emulation line is a two-way emulator interrupt whose direction is set by scan.
// [R7] With test reset low the second emulation line acts as an active-low global output-disable input.
// [R8] Output disable is active only for test reset low, first emulation line high and second low.
// [R9] While output disable is active every output driver, TDO included, is released.
// [R10] The outside party uses output disable only for test and emulation, never for bus sharing.
// [R11] The TAP controller follows the sixteen-state TMS sequence and is held in reset while test reset is low.
`default_nettype none

package test_port_pkg;

    typedef enum logic [3:0] {
        TEST_LOGIC_RESET, RUN_TEST_IDLE,
        SELECT_DR, CAPTURE_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR,
        UPDATE_DR,
        SELECT_IR, CAPTURE_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR,
        UPDATE_IR
    } tap_state_e;

    localparam int unsigned IR_WIDTH  = 4;
    localparam int unsigned EMU_LINES = 2;

    localparam logic [IR_WIDTH-1:0] INSTR_BYPASS  = 4'hf;
    localparam logic [IR_WIDTH-1:0] INSTR_EMU_DIR = 4'h2;
    localparam logic [IR_WIDTH-1:0] IR_CAPTURE    = 4'h1;
    localparam logic [IR_WIDTH-1:0] IR_RESET      = INSTR_BYPASS;

    localparam logic [EMU_LINES-1:0] EMU_DIR_RESET = 2'h0;

    // Positions in the synchronised pin vector
    localparam int unsigned PIN_TRST  = 0;
    localparam int unsigned PIN_EMU_A = 1;
    localparam int unsigned PIN_EMU_B = 2;
    localparam int unsigned PIN_COUNT = 3;
    // Test reset low, both emulation lines pulled high
    localparam logic [PIN_COUNT-1:0] PIN_RESET = 3'h6;

endpackage

`default_nettype wire

// ---- tap_state_machine.sv ----
// Sixteen-state TAP controller on the test clock
`default_nettype none

module tap_state_machine (
    input  wire logic                     i_tck,
    input  wire logic                     i_test_reset_n,
    input  wire logic                     i_tms,
    output test_port_pkg::tap_state_e     o_state
);
    import test_port_pkg::*;

    tap_state_e next_state;

    always_comb begin
        next_state = o_state;
        unique case (o_state)
            TEST_LOGIC_RESET: next_state = i_tms ? TEST_LOGIC_RESET
                                                 : RUN_TEST_IDLE;
            RUN_TEST_IDLE: next_state = i_tms ? SELECT_DR : RUN_TEST_IDLE;
            SELECT_DR:     next_state = i_tms ? SELECT_IR : CAPTURE_DR;
            CAPTURE_DR:    next_state = i_tms ? EXIT1_DR : SHIFT_DR;
            SHIFT_DR:      next_state = i_tms ? EXIT1_DR : SHIFT_DR;
            EXIT1_DR:      next_state = i_tms ? UPDATE_DR : PAUSE_DR;
            PAUSE_DR:      next_state = i_tms ? EXIT2_DR : PAUSE_DR;
            EXIT2_DR:      next_state = i_tms ? UPDATE_DR : SHIFT_DR;
            UPDATE_DR:     next_state = i_tms ? SELECT_DR : RUN_TEST_IDLE;
            SELECT_IR:     next_state = i_tms ? TEST_LOGIC_RESET
                                              : CAPTURE_IR;
            CAPTURE_IR:    next_state = i_tms ? EXIT1_IR : SHIFT_IR;
            SHIFT_IR:      next_state = i_tms ? EXIT1_IR : SHIFT_IR;
            EXIT1_IR:      next_state = i_tms ? UPDATE_IR : PAUSE_IR;
            PAUSE_IR:      next_state = i_tms ? EXIT2_IR : PAUSE_IR;
            EXIT2_IR:      next_state = i_tms ? UPDATE_IR : SHIFT_IR;
            UPDATE_IR:     next_state = i_tms ? SELECT_DR : RUN_TEST_IDLE;
        endcase
    end

    // Held in reset while test reset is low
    always_ff @(posedge i_tck or negedge i_test_reset_n) begin
        if (!i_test_reset_n) begin
            o_state <= TEST_LOGIC_RESET; // R11
        end else begin
            o_state <= next_state; // R1 R11
        end
    end

endmodule // tap_state_machine

`default_nettype wire

// ---- test_port_output_disable.sv ----
// Test access port, emulation lines and global output disable
`default_nettype none

module test_port_output_disable (
    input  wire logic                                i_ref_clk,
    input  wire logic                                i_reset_n,
    input  wire logic                                i_tck,
    input  wire logic                                i_test_reset_n,
    input  wire logic                                i_tms,
    input  wire logic                                i_tdi,
    output var  logic                                o_tdo,
    output logic                                     o_tdo_oe_n,
    input  wire logic                                i_emulation_line_a,
    output var  logic                                o_emulation_line_a,
    output var  logic                                o_emulation_line_a_oe_n,
    input  wire logic                    i_emulation_line_b_output_disable,
    output var  logic                    o_emulation_line_b_output_disable,
    output var  logic                    o_emulation_line_b_output_disable_oe_n,
    input  wire logic [test_port_pkg::EMU_LINES-1:0] i_core_emu_irq,
    output var  logic [test_port_pkg::EMU_LINES-1:0] o_emu_irq,
    output var  logic                                o_scan_control,
    output var  logic                                o_output_disable
);
    import test_port_pkg::*;

    // Test clock domain
    tap_state_e             state;
    logic [IR_WIDTH-1:0]    ir_shift;
    logic [IR_WIDTH-1:0]    instr;
    logic [EMU_LINES-1:0]   dir_shift;
    logic [EMU_LINES-1:0]   emu_dir;
    logic                   bypass;
    logic                   tdo_drive;
    logic                   shifting;
    // Reference clock domain
    logic [PIN_COUNT-1:0]   pins;
    logic [PIN_COUNT-1:0]   pin_s1;
    logic [PIN_COUNT-1:0]   pin_s2;
    logic [PIN_COUNT-1:0]   pin_s3;
    logic [PIN_COUNT-1:0]   pin_filt;
    logic [EMU_LINES-1:0]   dir_meta;
    logic [EMU_LINES-1:0]   dir_sync;
    logic [EMU_LINES-1:0]   line_in;
    logic                   scan_now;
    logic                   off_now;

    // Per bit: take the new level only when stages two and three agree
    function automatic logic [PIN_COUNT-1:0] agree(
        input logic [PIN_COUNT-1:0] held,
        input logic [PIN_COUNT-1:0] s2,
        input logic [PIN_COUNT-1:0] s3
    );
        agree = (s2 & s3) | (held & (s2 | s3));
    endfunction

    tap_state_machine u_tap (
        .i_tck          (i_tck),
        .i_test_reset_n (i_test_reset_n),
        .i_tms          (i_tms),
        .o_state        (state)
    );

    assign shifting = (state == SHIFT_DR) || (state == SHIFT_IR);

    // Instruction register
    always_ff @(posedge i_tck or negedge i_test_reset_n) begin
        if (!i_test_reset_n) begin
            ir_shift <= IR_RESET;
            instr    <= IR_RESET;
        end else begin
            unique case (state)
                TEST_LOGIC_RESET: instr    <= IR_RESET;
                CAPTURE_IR:       ir_shift <= IR_CAPTURE;
                SHIFT_IR:         ir_shift <= {i_tdi,
                                      ir_shift[IR_WIDTH-1:1]}; // R1
                UPDATE_IR:        instr    <= ir_shift;
                default:          ;
            endcase
        end
    end

    // Data registers: bypass and emulation line direction
    always_ff @(posedge i_tck or negedge i_test_reset_n) begin
        if (!i_test_reset_n) begin
            bypass    <= 1'b0;
            dir_shift <= EMU_DIR_RESET;
            emu_dir   <= EMU_DIR_RESET;
        end else begin
            unique case (state)
                TEST_LOGIC_RESET: emu_dir <= EMU_DIR_RESET;
                CAPTURE_DR: begin
                    bypass    <= 1'b0;
                    dir_shift <= emu_dir;
                end
                SHIFT_DR: begin
                    if (instr == INSTR_EMU_DIR) begin
                        dir_shift <= {i_tdi,
                                      dir_shift[EMU_LINES-1:1]}; // R1
                    end else begin
                        bypass <= i_tdi; // R1
                    end
                end
                UPDATE_DR: begin
                    if (instr == INSTR_EMU_DIR) begin
                        emu_dir <= dir_shift; // R6
                    end
                end
                default: ;
            endcase
        end
    end

    // TDO launched on the falling edge, driven only while shifting
    always_ff @(negedge i_tck or negedge i_test_reset_n) begin
        if (!i_test_reset_n) begin
            o_tdo     <= 1'b0;
            tdo_drive <= 1'b0;
        end else begin
            tdo_drive <= shifting; // R3
            if (state == SHIFT_IR) begin
                o_tdo <= ir_shift[0]; // R2
            end else if (state == SHIFT_DR) begin
                o_tdo <= (instr == INSTR_EMU_DIR) ? dir_shift[0]
                                                  : bypass; // R2
            end
        end
    end

    assign o_tdo_oe_n = !tdo_drive || o_output_disable; // R3 R9

    // Pin synchronisers in the reference domain
    assign pins = {i_emulation_line_b_output_disable, i_emulation_line_a,
                   i_test_reset_n};

    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            pin_s1   <= PIN_RESET;
            pin_s2   <= PIN_RESET;
            pin_s3   <= PIN_RESET;
            pin_filt <= PIN_RESET;
        end else begin
            pin_s1   <= pins;
            pin_s2   <= pin_s1;
            pin_s3   <= pin_s2;
            pin_filt <= agree(pin_filt, pin_s2, pin_s3);
        end
    end

    // Direction bits cross from the test clock as levels
    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            dir_meta <= EMU_DIR_RESET;
            dir_sync <= EMU_DIR_RESET;
        end else begin
            dir_meta <= emu_dir;
            dir_sync <= dir_meta;
        end
    end

    assign scan_now = pin_filt[PIN_TRST]; // R4 R5
    assign off_now  = !pin_filt[PIN_TRST] && pin_filt[PIN_EMU_A]
                      && !pin_filt[PIN_EMU_B]; // R7 R8
    assign line_in  = {pin_filt[PIN_EMU_B], pin_filt[PIN_EMU_A]};

    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            o_scan_control   <= 1'b0;
            o_output_disable <= 1'b0;
            o_emu_irq        <= '0;
        end else begin
            o_scan_control   <= scan_now; // R4
            o_output_disable <= off_now; // R8
            o_emu_irq        <= scan_now ? (line_in & ~dir_sync)
                                         : '0; // R5 R6 R7
        end
    end

    // Emulation line drivers, released when not driving or when disabled
    always_ff @(posedge i_ref_clk) begin
        if (!i_reset_n) begin
            o_emulation_line_a                     <= 1'b0;
            o_emulation_line_b_output_disable      <= 1'b0;
            o_emulation_line_a_oe_n                <= 1'b1;
            o_emulation_line_b_output_disable_oe_n <= 1'b1;
        end else begin
            o_emulation_line_a                <= i_core_emu_irq[0];
            o_emulation_line_b_output_disable <= i_core_emu_irq[1];
            o_emulation_line_a_oe_n <=
                !(scan_now && dir_sync[0] && !off_now); // R6 R9
            o_emulation_line_b_output_disable_oe_n <=
                !(scan_now && dir_sync[1] && !off_now); // R6 R9
        end
    end

    // Test clock domain checks
    tdi_capture_a: assert property ( // R1
        @(posedge i_tck) disable iff (!i_test_reset_n)
        (state == SHIFT_DR && instr == INSTR_BYPASS)
            |=> bypass == $past(i_tdi))
        else $error("bypass bit did not take TDI");

    tdo_ir_data_a: assert property ( // R2
        @(posedge i_tck) disable iff (!i_test_reset_n)
        (state == SHIFT_IR && $past(state) == SHIFT_IR)
            |-> o_tdo == ir_shift[0])
        else $error("TDO does not show instruction shift bit");

    tdo_idle_a: assert property ( // R3
        @(posedge i_tck) disable iff (!i_test_reset_n)
        !shifting ##1 !shifting |-> o_tdo_oe_n)
        else $error("TDO driven outside a scan");

    tap_hold_a: assert property ( // R11
        @(posedge i_tck) disable iff (!i_test_reset_n)
        (i_tms [*5]) |=> state == TEST_LOGIC_RESET)
        else $error("five TMS highs did not reach reset state");

    // Reference domain checks
    scan_mode_a: assert property ( // R4
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        o_scan_control == $past(pin_filt[PIN_TRST]))
        else $error("scan control does not follow test reset");

    func_quiet_a: assert property ( // R5
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        !o_scan_control |-> o_emu_irq == '0 && o_emulation_line_a_oe_n
            && o_emulation_line_b_output_disable_oe_n)
        else $error("emulation lines active in functional mode");

    emu_drive_a: assert property ( // R6
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        $past(pin_filt[PIN_TRST] && dir_sync[0])
            |-> !o_emulation_line_a_oe_n)
        else $error("emulation line a not driven when set");

    off_input_a: assert property ( // R7
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        o_output_disable |-> !o_scan_control && o_emu_irq == '0)
        else $error("output disable seen as interrupt");

    off_combo_a: assert property ( // R8
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        o_output_disable == $past(!pin_filt[PIN_TRST]
            && pin_filt[PIN_EMU_A] && !pin_filt[PIN_EMU_B]))
        else $error("output disable from wrong pin combination");

    off_tristate_a: assert property ( // R9
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        o_output_disable |-> o_tdo_oe_n && o_emulation_line_a_oe_n
            && o_emulation_line_b_output_disable_oe_n)
        else $error("driver active during output disable");

    cover_dir_scan: cover property (
        @(posedge i_tck) disable iff (!i_test_reset_n)
        state == UPDATE_DR && instr == INSTR_EMU_DIR);
    cover_off: cover property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        $rose(o_output_disable));
    cover_irq_in: cover property (
        @(posedge i_ref_clk) disable iff (!i_reset_n)
        o_emu_irq != '0);
    cover_tdo: cover property (
        @(posedge i_tck) disable iff (!i_test_reset_n)
        !o_tdo_oe_n);

endmodule // test_port_output_disable

`default_nettype wire

// ---- test_ctrl_model.sv ----
// Behavioural external test controller driving the link pins
`default_nettype none

module test_ctrl_model (
    input  wire logic       i_tdo,
    input  wire logic       i_tdo_oe_n,
    output var  logic       o_tck,
    output var  logic       o_tms,
    output var  logic       o_tdi,
    output var  logic       o_test_reset_n,
    output var  logic [1:0] o_emu_en,
    output var  logic [1:0] o_emu_val
);
    timeunit 1ns;
    timeprecision 1ps;

    logic noise  = 1'b0;
    logic oe_seen = 1'b1;
    // Released line shows a changing pattern, never a held value
    wire  tdo_line = i_tdo_oe_n ? noise : i_tdo;

    initial begin
        o_tck = 1'b0;
        o_tms = 1'b1;
        o_tdi = 1'b1;
        o_test_reset_n = 1'b0;
        o_emu_en = 2'h0;
        o_emu_val = 2'h0;
    end

    // One test clock period; clock stands low between frames
    task automatic tick(input logic tms, input logic tdi, output logic seen);
        o_tms = tms;
        o_tdi = tdi;
        #40;
        seen = tdo_line;
        oe_seen = i_tdo_oe_n;
        noise = ~noise;
        #40 o_tck = 1'b1;
        #80 o_tck = 1'b0;
    endtask

    // Change reset only while the clock is low; on release, settle in idle
    task automatic set_trst(input logic v);
        logic s;
        o_test_reset_n = v;
        #40;
        if (v) begin
            tick(1'b0, 1'b0, s);
        end
    endtask

    // Full scan from idle back to idle, LSB first
    task automatic scan(input logic is_ir, input int n, input logic [7:0] din,
                        output logic [7:0] dout, output logic driven);
        logic s;
        int   i;
        dout = 8'h00;
        driven = 1'b1;
        tick(1'b1, 1'b0, s);
        if (is_ir) begin
            tick(1'b1, 1'b0, s);
        end
        tick(1'b0, 1'b0, s);
        tick(1'b0, 1'b0, s);
        for (i = 0; i < n; i++) begin
            tick(i == n - 1, din[i], s);
            dout[i] = s;
            driven = driven & ~oe_seen;
        end
        tick(1'b1, 1'b0, s);
        tick(1'b0, 1'b0, s);
    endtask

    // Drive emulation lines; off request only in test use
    task automatic set_pins(input logic [1:0] en, input logic [1:0] val);
        o_emu_en = en;
        o_emu_val = val;
    endtask
endmodule // test_ctrl_model

`default_nettype wire

// ---- test_port_output_disable_tb.sv ----
// Self-checking bench for the test port and output disable block
`default_nettype none

module test_port_output_disable_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic       ref_clk  = 1'b0;
    logic       reset_n  = 1'b0;
    logic [1:0] core_irq = 2'h0;
    logic       tck, tms, tdi, trst_n, tdo, tdo_oe_n;
    logic       a_out, a_oe_n, b_out, b_oe_n, scan_ctl, off;
    logic [1:0] m_en, m_val, emu_irq;
    logic [7:0] dout;
    logic       drv;
    int         bad_count = 0;
    int         n_tests   = 0;
    int         cycles    = 0;
    // Pulled-up lines: device, then controller, then pull-up
    wire line_a = !a_oe_n ? a_out : (m_en[0] ? m_val[0] : 1'b1);
    wire line_b = !b_oe_n ? b_out : (m_en[1] ? m_val[1] : 1'b1);

    always #10 ref_clk = ~ref_clk;

    test_port_output_disable dut_u (
        .i_ref_clk(ref_clk), .i_reset_n(reset_n), .i_tck(tck),
        .i_test_reset_n(trst_n), .i_tms(tms), .i_tdi(tdi),
        .o_tdo(tdo), .o_tdo_oe_n(tdo_oe_n),
        .i_emulation_line_a(line_a), .o_emulation_line_a(a_out),
        .o_emulation_line_a_oe_n(a_oe_n),
        .i_emulation_line_b_output_disable(line_b),
        .o_emulation_line_b_output_disable(b_out),
        .o_emulation_line_b_output_disable_oe_n(b_oe_n),
        .i_core_emu_irq(core_irq), .o_emu_irq(emu_irq),
        .o_scan_control(scan_ctl), .o_output_disable(off)
    );

    test_ctrl_model ctl_u (
        .i_tdo(tdo), .i_tdo_oe_n(tdo_oe_n), .o_tck(tck), .o_tms(tms),
        .o_tdi(tdi), .o_test_reset_n(trst_n), .o_emu_en(m_en),
        .o_emu_val(m_val)
    );

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        if (bad_count == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        // Step off the edge so pin changes and checks never race it
        #3;
    endtask

    task automatic t_reset();
        check(scan_ctl, 1'b0);
        check(off, 1'b0);
        check({b_oe_n, a_oe_n, tdo_oe_n}, 3'h7);
        check(emu_irq, 2'h0);
    endtask

    task automatic t_scan();
        ctl_u.set_trst(1'b1);
        cyc(10);
        check(scan_ctl, 1'b1);
        ctl_u.scan(1'b1, 4, 8'h02, dout, drv);
        check(dout, 8'h01);
        check(drv, 1'b1);
        check(tdo_oe_n, 1'b1);
    endtask

    task automatic t_emu();
        ctl_u.scan(1'b0, 4, 8'h0d, dout, drv);
        check(dout[3:2], 2'h1);
        cyc(1);
        core_irq <= 2'h2;
        cyc(10);
        check({b_oe_n, a_oe_n}, 2'h0);
        check({line_b, line_a}, 2'h2);
        ctl_u.scan(1'b0, 2, 8'h01, dout, drv);
        ctl_u.set_pins(2'h2, 2'h0);
        cyc(10);
        check({b_oe_n, a_oe_n}, 2'h2);
        check(emu_irq, 2'h0);
        ctl_u.set_pins(2'h2, 2'h2);
        cyc(10);
        check(emu_irq, 2'h2);
        ctl_u.set_pins(2'h0, 2'h0);
    endtask

    task automatic t_func();
        ctl_u.set_trst(1'b0);
        cyc(10);
        check(scan_ctl, 1'b0);
        check({b_oe_n, a_oe_n, emu_irq}, 4'hc);
        ctl_u.scan(1'b1, 4, 8'h0f, dout, drv);
        check(drv, 1'b0);
        ctl_u.set_trst(1'b1);
        ctl_u.scan(1'b1, 4, 8'h0f, dout, drv);
        check(dout, 8'h01);
    endtask

    task automatic t_off();
        int i;
        ctl_u.set_trst(1'b0);
        for (i = 0; i < 4; i++) begin
            ctl_u.set_pins(2'h3, i[1:0]);
            cyc(10);
            check(off, i == 1);
            check({tdo_oe_n, b_oe_n, a_oe_n}, 3'h7);
        end
        ctl_u.set_trst(1'b1);
        ctl_u.set_pins(2'h3, 2'h1);
        cyc(10);
        check(off, 1'b0);
        ctl_u.set_pins(2'h0, 2'h0);
    endtask

    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            wrap_up();
        end
    end

    initial begin
        cyc(10);
        reset_n <= 1'b1;
        cyc(6);
        t_reset();
        t_scan();
        t_emu();
        t_func();
        t_off();
        wrap_up();
    end
endmodule // test_port_output_disable_tb

`default_nettype wire
